// File: shared/seewp_pkg.sv
// constants, encodings and states of the serial eeprom word port
// assumes a 40 MHz core clock that samples every input pin of the serial link
package seewp_pkg;
    // ----------------------------------------------------------------
    // clock and timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 25;
    localparam int PROG_TIME_3V_MS = 15;
    localparam int PROG_TIME_5V_MS = 10;
    // longest time: rounded down
    localparam int PROG_CYC_3V = PROG_TIME_3V_MS * 1000000 / CLK_PERIOD_NS;
    localparam int PROG_CYC_5V = PROG_TIME_5V_MS * 1000000 / CLK_PERIOD_NS;
    localparam int BUSY_MAX_NS = 1000;
    localparam int BUSY_CYC = BUSY_MAX_NS / CLK_PERIOD_NS;
    // obligations of the host, kept for the bench
    localparam int DESELECT_MIN_TIME_NS = 1000;
    localparam int POLL_SCK_LOW_NS = 500;

    // ----------------------------------------------------------------
    // frame layout
    // ----------------------------------------------------------------
    localparam int ADDR_W = 7;
    localparam int WORD_W = 16;
    localparam int WORDS = 128;
    localparam int PCNT_W = 20;
    localparam logic [3:0] START_PAT = 4'ha;
    localparam logic [3:0] OP_READ = 4'h8;
    localparam logic [3:0] OP_WRITE = 4'h4;
    localparam logic [3:0] OP_ALLOW = 4'h3;
    localparam logic [3:0] OP_FORBID = 4'h0;
    localparam logic [4:0] OP_LAST = 5'h03;
    localparam logic [4:0] ADDR_LAST = 5'h07;
    localparam logic [4:0] DATA_LAST = 5'h0f;
    localparam logic [WORD_W-1:0] ERASED = 16'hffff;

    // ----------------------------------------------------------------
    // pin synchroniser lanes
    // ----------------------------------------------------------------
    localparam int LN_SEL = 0;
    localparam int LN_SCK = 1;
    localparam int LN_SI = 2;
    localparam int LN_WG = 3;
    localparam logic [3:0] SYNC_RST = 4'h9;

    typedef enum logic [2:0] {
        st_hunt,
        st_op,
        st_addr,
        st_data,
        st_read,
        st_done
    } seewp_state_t;
endpackage : seewp_pkg

// File: shared/seewp_store_if.sv
// read and write ports between the frame logic and the word store
// assumes both ends sit on the same core clock
`timescale 1ns/1ps
interface seewp_store_if;
    logic [6:0]  rd_addr;
    logic [15:0] rd_data;
    logic        wr_en;
    logic [6:0]  wr_addr;
    logic [15:0] wr_data;

    modport core  (output rd_addr, input rd_data,
                   output wr_en, output wr_addr, output wr_data);
    modport store (input rd_addr, output rd_data,
                   input wr_en, input wr_addr, input wr_data);
endinterface : seewp_store_if

// File: logic/seewp_word_store.sv
// word array of the eeprom, held in flip-flops
// assumes one write at most per clock, issued by the frame logic
`timescale 1ns/1ps
module seewp_word_store (
    // clock and reset
    input wire logic        clk,
    input wire logic        rst_b,
    // access port
    seewp_store_if.store    st
);
    logic [15:0] word_reg [seewp_pkg::WORDS];

    // ----------------------------------------------------------------
    // storage, one flop row per word
    // ----------------------------------------------------------------
    for (genvar i = 0; i < seewp_pkg::WORDS; i++) begin : g_word
        always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
                word_reg[i] <= seewp_pkg::ERASED;
            end else if (st.wr_en && st.wr_addr == 7'(i)) begin
                word_reg[i] <= st.wr_data;
            end
        end
    end

    assign st.rd_data = word_reg[st.rd_addr];
endmodule : seewp_word_store

// File: logic/seewp_core.sv
// serial eeprom word port: frame decode, write latch, program timer
// assumes the link pins are asynchronous to clk and the serial clock
// is far slower than clk, so every pin edge is seen by sampling
`timescale 1ns/1ps
// Contract
// - sample serial input on clock rise; change serial output on fall
// - frame is 1010 start, four-bit opcode, seven address bits, dummy
// - write carries sixteen data bits after address; exactly those taken
// - bits before a 1010 start pattern are ignored
// - opcode 1000 reads, 0100 writes, both with word address
// - opcode 0011 sets write latch, 0000 clears it; address ignored
// - read loads addressed word and shifts it out; nothing else drives data
// - write starts programming once last data bit lands on edge 32
// - ready/busy low within 1 us of edge 32, high after finishing
// - select low while programming shows busy on serial output
// - deselect floats output; after programming it shows high until SI rises
// - write guard high blocks writes and leaves device ready
// - write guard change during programming aborts the write
// - write guard has no effect on read, allow or forbid
// - write latch clear after reset; writes refused until allowed
// - write latch stays set over many writes until forbid
// - clearing write latch does not touch reads
// - internal timer times programming, 15 ms or 10 ms maximum
// - store holds 128 words of 16 bits, one per address
module seewp_core #(
    parameter int PROG_CYCLES = seewp_pkg::PROG_CYC_5V
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_b,
    // serial link pins
    input  wire logic sel_n_pin,
    input  wire logic sck_pin,
    input  wire logic si_pin,
    output logic      so_o,
    output logic      so_oe_n,
    // write guard and status
    input  wire logic write_guard_n,
    output logic      ready_busy
);
    localparam int busy_win = seewp_pkg::BUSY_CYC;

    seewp_store_if st ();

    seewp_word_store u_store (
        .clk   (clk),
        .rst_b (rst_b),
        .st    (st.store)
    );

    // ----------------------------------------------------------------
    // pin synchronisers and edge finders
    // ----------------------------------------------------------------
    logic [3:0] meta_reg;
    logic [3:0] sync_reg;
    logic [3:0] prev_reg;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_reg <= seewp_pkg::SYNC_RST;
            sync_reg <= seewp_pkg::SYNC_RST;
            prev_reg <= seewp_pkg::SYNC_RST;
        end else begin
            meta_reg <= {write_guard_n, si_pin, sck_pin, sel_n_pin};
            sync_reg <= meta_reg;
            prev_reg <= sync_reg;
        end
    end

    logic sel_n_s;
    logic si_s;
    logic wg_s;
    logic sck_rise;
    logic sck_fall;
    logic si_rise;
    assign sel_n_s = sync_reg[seewp_pkg::LN_SEL];
    assign si_s = sync_reg[seewp_pkg::LN_SI];
    assign wg_s = sync_reg[seewp_pkg::LN_WG];
    assign sck_rise = sync_reg[seewp_pkg::LN_SCK]
                    & ~prev_reg[seewp_pkg::LN_SCK];
    assign sck_fall = ~sync_reg[seewp_pkg::LN_SCK]
                    & prev_reg[seewp_pkg::LN_SCK];
    assign si_rise = si_s & ~prev_reg[seewp_pkg::LN_SI];

    // ----------------------------------------------------------------
    // frame decoder
    // ----------------------------------------------------------------
    seewp_pkg::seewp_state_t state_reg;
    logic [3:0]  pat_reg;
    logic [4:0]  cnt_reg;
    logic [15:0] sh_reg;
    logic [3:0]  op_reg;
    logic [6:0]  addr_reg;
    logic [15:0] out_sh_reg;
    logic        wen_reg;
    logic        prog_busy_reg;

    function automatic logic op_is(input logic [3:0] op,
                                   input logic [3:0] code);
        op_is = (op == code);
    endfunction : op_is

    logic live;
    logic addr_done;
    logic data_done;
    logic allow_hit;
    logic forbid_hit;
    logic prog_start;
    logic [15:0] wdata;
    // a busy device or a dropped select sends decoding back to hunt
    assign live = ~sel_n_s & ~prog_busy_reg;
    assign addr_done = live & sck_rise & (state_reg == seewp_pkg::st_addr)
                     & (cnt_reg == seewp_pkg::ADDR_LAST);
    assign data_done = live & sck_rise & (state_reg == seewp_pkg::st_data)
                     & (cnt_reg == seewp_pkg::DATA_LAST);
    assign allow_hit = addr_done & op_is(op_reg, seewp_pkg::OP_ALLOW);
    assign forbid_hit = addr_done & op_is(op_reg, seewp_pkg::OP_FORBID);
    assign wdata = {sh_reg[14:0], si_s};
    // guard and latch only gate the write itself
    assign prog_start = data_done & wen_reg & ~wg_s;
    assign st.rd_addr = sh_reg[6:0];

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg <= seewp_pkg::st_hunt;
            pat_reg <= 4'h0;
            cnt_reg <= 5'h00;
            sh_reg <= 16'h0000;
            op_reg <= 4'h0;
            addr_reg <= 7'h00;
            out_sh_reg <= 16'h0000;
        end else if (!live) begin
            state_reg <= seewp_pkg::st_hunt;
            pat_reg <= 4'h0;
            cnt_reg <= 5'h00;
        end else if (sck_rise) begin
            sh_reg <= {sh_reg[14:0], si_s};
            cnt_reg <= cnt_reg + 5'h01;
            unique case (state_reg)
                seewp_pkg::st_hunt: begin
                    pat_reg <= {pat_reg[2:0], si_s};
                    cnt_reg <= 5'h00;
                    if ({pat_reg[2:0], si_s} == seewp_pkg::START_PAT) begin
                        state_reg <= seewp_pkg::st_op;
                    end
                end
                seewp_pkg::st_op: begin
                    if (cnt_reg == seewp_pkg::OP_LAST) begin
                        op_reg <= {sh_reg[2:0], si_s};
                        cnt_reg <= 5'h00;
                        state_reg <= seewp_pkg::st_addr;
                    end
                end
                seewp_pkg::st_addr: begin
                    if (cnt_reg == seewp_pkg::ADDR_LAST) begin
                        // seven address bits, the dummy bit dropped
                        addr_reg <= sh_reg[6:0];
                        cnt_reg <= 5'h00;
                        state_reg <= seewp_pkg::st_done;
                        if (op_is(op_reg, seewp_pkg::OP_READ)) begin
                            out_sh_reg <= st.rd_data;
                            state_reg <= seewp_pkg::st_read;
                        end
                        if (op_is(op_reg, seewp_pkg::OP_WRITE)) begin
                            state_reg <= seewp_pkg::st_data;
                        end
                    end
                end
                seewp_pkg::st_data: begin
                    if (cnt_reg == seewp_pkg::DATA_LAST) begin
                        // further bits before deselect are not taken
                        state_reg <= seewp_pkg::st_done;
                    end
                end
                seewp_pkg::st_read: begin
                    cnt_reg <= 5'h00;
                end
                seewp_pkg::st_done: begin
                    cnt_reg <= 5'h00;
                end
            endcase
        end else if (sck_fall && state_reg == seewp_pkg::st_read) begin
            out_sh_reg <= {out_sh_reg[14:0], 1'b0};
        end
    end

    // ----------------------------------------------------------------
    // write enable latch
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wen_reg <= 1'b0;
        end else if (allow_hit) begin
            wen_reg <= 1'b1;
        end else if (forbid_hit) begin
            wen_reg <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // self-timed programming
    // ----------------------------------------------------------------
    logic [19:0] pcnt_reg;
    logic [6:0]  paddr_reg;
    logic [15:0] pdata_reg;
    logic        pwg_reg;
    logic        prog_end;
    logic        prog_abort;
    logic        prog_stop_reg;
    logic        done_hold_reg;
    assign prog_end = prog_busy_reg
                    & (pcnt_reg == 20'(PROG_CYCLES - 1));
    assign prog_abort = prog_busy_reg & (wg_s != pwg_reg);

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            prog_busy_reg <= 1'b0;
            pcnt_reg <= 20'h00000;
            paddr_reg <= 7'h00;
            pdata_reg <= 16'h0000;
            pwg_reg <= 1'b1;
            prog_stop_reg <= 1'b0;
        end else begin
            prog_stop_reg <= prog_end | prog_abort;
            if (prog_start) begin
                prog_busy_reg <= 1'b1;
                pcnt_reg <= 20'h00000;
                paddr_reg <= addr_reg;
                pdata_reg <= wdata;
                pwg_reg <= wg_s;
            end else if (prog_end || prog_abort) begin
                prog_busy_reg <= 1'b0;
            end else if (prog_busy_reg) begin
                pcnt_reg <= pcnt_reg + 20'h00001;
            end
        end
    end

    // the word is erased at the start; an aborted write leaves it erased
    assign st.wr_en = prog_start | prog_end | prog_abort;
    assign st.wr_addr = prog_start ? addr_reg : paddr_reg;
    assign st.wr_data = prog_end ? pdata_reg : seewp_pkg::ERASED;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ready_busy <= 1'b1;
        end else begin
            ready_busy <= ~(prog_busy_reg | prog_start);
        end
    end

    // ----------------------------------------------------------------
    // serial output driver
    // ----------------------------------------------------------------
    logic rd_drive_reg;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            done_hold_reg <= 1'b0;
        end else if (prog_stop_reg) begin
            done_hold_reg <= 1'b1;
        end else if (si_rise) begin
            done_hold_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rd_drive_reg <= 1'b0;
            so_o <= 1'b1;
            so_oe_n <= 1'b1;
        end else if (prog_busy_reg && !sel_n_s) begin
            so_o <= 1'b0;
            so_oe_n <= 1'b0;
            rd_drive_reg <= 1'b0;
        end else if (done_hold_reg) begin
            so_o <= 1'b1;
            so_oe_n <= 1'b0;
            rd_drive_reg <= 1'b0;
        end else if (live && state_reg == seewp_pkg::st_read) begin
            if (sck_fall) begin
                so_o <= out_sh_reg[15];
                rd_drive_reg <= 1'b1;
            end
            so_oe_n <= ~(rd_drive_reg | sck_fall);
        end else begin
            so_oe_n <= 1'b1;
            rd_drive_reg <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    sequence s_start_seen;
        prog_start;
    endsequence

    sequence s_busy_shown;
        ##[1:busy_win] !ready_busy;
    endsequence

    property p_busy_fast;
        @(posedge clk) disable iff (!rst_b)
        s_start_seen |-> s_busy_shown;
    endproperty
    a_busy_fast: assert property (p_busy_fast)
        else $error("ready/busy not low in time after last data bit");

    property p_ready_cause;
        @(posedge clk) disable iff (!rst_b)
        $rose(ready_busy) |-> $past(prog_stop_reg) || $past(prog_end)
            || $past(prog_abort);
    endproperty
    a_ready_cause: assert property (p_ready_cause)
        else $error("ready/busy rose without programming ending");

    property p_latch_gates;
        @(posedge clk) disable iff (!rst_b)
        prog_start |-> wen_reg && !wg_s && state_reg == seewp_pkg::st_data;
    endproperty
    a_latch_gates: assert property (p_latch_gates)
        else $error("programming started while writes were not allowed");

    property p_guard_lock;
        @(posedge clk) disable iff (!rst_b)
        wg_s && ready_busy && !prog_start |=> ready_busy;
    endproperty
    a_guard_lock: assert property (p_guard_lock)
        else $error("device went busy with write guard high");

    property p_abort;
        @(posedge clk) disable iff (!rst_b)
        prog_busy_reg && $changed(wg_s) |=> !prog_busy_reg ##1 ready_busy;
    endproperty
    a_abort: assert property (p_abort)
        else $error("guard change did not abort programming");

    property p_allow;
        @(posedge clk) disable iff (!rst_b)
        allow_hit |=> wen_reg [*2];
    endproperty
    a_allow: assert property (p_allow)
        else $error("allow command did not set the write latch");

    property p_poll;
        @(posedge clk) disable iff (!rst_b)
        prog_busy_reg && !sel_n_s |=> !so_oe_n && !so_o;
    endproperty
    a_poll: assert property (p_poll)
        else $error("busy not shown on serial output during poll");

    property p_float;
        @(posedge clk) disable iff (!rst_b)
        $rose(sel_n_s) && !done_hold_reg && !prog_stop_reg |=> so_oe_n;
    endproperty
    a_float: assert property (p_float)
        else $error("serial output still driven after deselect");

    property p_so_on_fall;
        @(posedge clk) disable iff (!rst_b)
        state_reg == seewp_pkg::st_read && !so_oe_n && $past(!so_oe_n)
            && $changed(so_o) |-> $past(sck_fall);
    endproperty
    a_so_on_fall: assert property (p_so_on_fall)
        else $error("read data changed away from a falling clock edge");
endmodule : seewp_core

// File: test/seewp_host.sv
// host side of the serial link: select, serial clock and data in
// assumes the bench resolves the serial output line before it reaches us
`timescale 1ns/1ps
module seewp_host (
    // link pins driven by the host
    output logic     sel_n,
    output logic     sck,
    output logic     si,
    // resolved serial output line
    input wire logic so_w
);
    // ----------------------------------------------------------------
    // idle levels: clock parked low, so it stands still between frames
    // ----------------------------------------------------------------
    initial begin
        sel_n = 1'b1;
        sck   = 1'b0;
        si    = 1'b0;
    end

    // odd 3 ns keeps link edges off the core clock edges
    task automatic gap;
        sel_n = 1'b1;
        #1003;
    endtask : gap

    task automatic sel(input logic v);
        sel_n = v;
    endtask : sel

    // sends bits[n-1:0] first to last; rd keeps the last 16 samples
    task automatic xfer(input logic [33:0] bits, input int n,
                        output logic [15:0] rd);
        rd = 16'h0000;
        sel_n = 1'b0;
        #200;
        for (int i = n - 1; i >= 0; i--) begin
            si = bits[i];
            #100;
            // output moves on the fall, so sample just before the rise
            rd = {rd[14:0], so_w};
            sck = 1'b1;
            #100;
            sck = 1'b0;
        end
        #100;
        sel_n = 1'b1;
        si = 1'b0;
    endtask : xfer
endmodule : seewp_host

// File: test/testbench.sv
// self-checking bench of the serial eeprom word port
// assumes seewp_pkg, the store interface and both design modules compiled
`timescale 1ns/1ps
module testbench;
    typedef struct {logic [6:0] a; logic [15:0] d;} seewp_row_t;
    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        write_guard_n = 1'b1;
    logic        sel_n, sck, si, so_o, so_oe_n, ready_busy, so_w;
    logic [15:0] rd;
    int          n_mismatch = 0;
    int          n_tests = 0;
    seewp_row_t  rows [4] = '{'{7'h00, 16'h1234}, '{7'h7f, 16'ha5c3},
                             '{7'h40, 16'h0001}, '{7'h01, 16'hfffe}};

    always #12.5 clk = ~clk;
    // a floating line shows the inverse of its last level
    assign so_w = so_oe_n ? ~so_o : so_o;

    seewp_core #(.PROG_CYCLES(200)) dut (
        .clk(clk), .rst_b(rst_b), .sel_n_pin(sel_n), .sck_pin(sck),
        .si_pin(si), .so_o(so_o), .so_oe_n(so_oe_n),
        .write_guard_n(write_guard_n), .ready_busy(ready_busy));
    seewp_host host (.sel_n(sel_n), .sck(sck), .si(si), .so_w(so_w));

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic check(input logic ok, input string msg);
        n_tests++;
        if (ok !== 1'b1) begin
            n_mismatch++;
            $display("ERROR %0t %s", $time, msg);
        end
    endtask : check

    task automatic report_and_stop;
        $display("tests %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : report_and_stop

    task automatic guard(input logic v);
        @(posedge clk);
        #1 write_guard_n = v;
    endtask : guard

    // frame laid out whole; short counts send only its leading bits
    task automatic cmd(input logic [3:0] op, input logic [6:0] a,
                       input logic [15:0] d, input int n);
        logic [31:0] f;
        f = {4'ha, op, a, 1'b0, d} >> (32 - n);
        host.gap;
        host.xfer({2'b00, f}, n, rd);
    endtask : cmd

    task automatic wait_ready;
        // look just after the edge, once the registered flag has settled
        for (int i = 0; i < 400 && ready_busy !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        if (ready_busy !== 1'b1) begin
            check(1'b0, "programming never finished");
            report_and_stop;
        end
    endtask : wait_ready

    task automatic wr(input logic [6:0] a, input logic [15:0] d,
                      input logic take);
        cmd(seewp_pkg::OP_WRITE, a, d, 32);
        check(ready_busy === ~take, "busy after write");
        wait_ready;
    endtask : wr

    task automatic rd_chk(input logic [6:0] a, input logic [15:0] d);
        cmd(seewp_pkg::OP_READ, a, 16'h0000, 32);
        check(rd === d, "read data");
    endtask : rd_chk

    initial begin
        repeat (4) @(posedge clk);
        #1 rst_b = 1'b1;
        check(ready_busy === 1'b1 && so_oe_n === 1'b1, "reset");
        // ------------------------------------------------------------
        // writes before the latch is set are refused
        // ------------------------------------------------------------
        guard(1'b0);
        wr(7'h05, 16'h5555, 1'b0);
        rd_chk(7'h05, seewp_pkg::ERASED);
        cmd(seewp_pkg::OP_ALLOW, 7'h55, 16'h0000, 16);
        // ------------------------------------------------------------
        // ordinary rows: many writes on one latch setting
        // ------------------------------------------------------------
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d, 1'b1);
            // done-hold reaches the pin one edge after ready rises
            repeat (2) @(posedge clk);
            #1;
            check(so_oe_n === 1'b0 && so_o === 1'b1, "hold");
            rd_chk(rows[i].a, rows[i].d);
            #200;
            check(so_oe_n === 1'b1, "output float");
            $display("row %0d done", i);
        end
        rd_chk(7'h00, 16'h1234);
        cmd(seewp_pkg::OP_FORBID, 7'h2a, 16'h0000, 16);
        wr(7'h00, 16'h0000, 1'b0);
        rd_chk(7'h00, 16'h1234);
        $display("latch test done");
        // ------------------------------------------------------------
        // guard: refuses writes, leaves allow alone
        // ------------------------------------------------------------
        guard(1'b1);
        cmd(seewp_pkg::OP_ALLOW, 7'h00, 16'h0000, 16);
        wr(7'h02, 16'hbeef, 1'b0);
        rd_chk(7'h02, seewp_pkg::ERASED);
        guard(1'b0);
        wr(7'h02, 16'hbeef, 1'b1);
        rd_chk(7'h02, 16'hbeef);
        $display("guard test done");
        // ------------------------------------------------------------
        // status poll on the serial output during programming
        // ------------------------------------------------------------
        cmd(seewp_pkg::OP_WRITE, 7'h04, 16'habcd, 32);
        host.gap;
        host.sel(1'b0);
        repeat (12) @(posedge clk);
        #1;
        check(so_oe_n === 1'b0 && so_o === 1'b0, "busy shown");
        host.sel(1'b1);
        repeat (12) @(posedge clk);
        #1;
        check(so_oe_n === 1'b1, "float after poll");
        wait_ready;
        rd_chk(7'h04, 16'habcd);
        $display("poll test done");
        // ------------------------------------------------------------
        // guard change mid-program aborts the write
        // ------------------------------------------------------------
        cmd(seewp_pkg::OP_WRITE, 7'h06, 16'h7777, 32);
        guard(1'b1);
        repeat (4) @(posedge clk);
        #1;
        check(ready_busy === 1'b1, "abort ends busy");
        guard(1'b0);
        rd_chk(7'h06, seewp_pkg::ERASED);
        $display("abort test done");
        // ------------------------------------------------------------
        // frame cut one bit short, then junk before the start pattern
        // ------------------------------------------------------------
        cmd(seewp_pkg::OP_WRITE, 7'h08, 16'h0f0f, 31);
        #200;
        check(ready_busy === 1'b1, "partial write idle");
        rd_chk(7'h08, seewp_pkg::ERASED);
        host.gap;
        host.xfer({2'b01, 4'ha, seewp_pkg::OP_READ, 7'h7f, 17'h0}, 34, rd);
        check(rd === 16'ha5c3, "read after junk");
        $display("edge test done");
        report_and_stop;
    end
endmodule : testbench
